// [common/brb_map.svh]
`ifndef BRB_MAP_SVH
`define BRB_MAP_SVH
// Register pointer values
`define BRB_OFS_ID 8'h00
`define BRB_OFS_SPARE 8'h01
`define BRB_OFS_CEIL 8'h02
`define BRB_OFS_RSVA 8'h03
`define BRB_OFS_STATUS 8'h04
`define BRB_OFS_CONFIG 8'h05
`define BRB_OFS_SLEW 8'h06
`define BRB_OFS_TARGET 8'h07
`define BRB_OFS_RSVB 8'h2B
// Status field positions
`define BRB_ST_TRIM 7
`define BRB_ST_THERM 5
`define BRB_ST_LOW 4
`define BRB_ST_HIGH 3
`define BRB_ST_OVERCUR 2
`define BRB_ST_CEIL 1
// Configuration field positions
`define BRB_CFG_STEP 7
`define BRB_CFG_FORCE 3
`define BRB_CFG_SPREAD 2
`define BRB_CFG_ROLE_HI 1
`define BRB_CFG_ROLE_LO 0
// Field high bit positions and reset values
`define BRB_SLEW_HI 3
`define BRB_CODE_HI 6
`define BRB_STATUS_RST 8'h00
`define BRB_ROLE_INPUT 2'h0
`endif

// [common/brb_pkg.sv]
package brb_pkg;

typedef enum logic [0:0] {
	BRB_LOAD_OTP,
	BRB_RUN
} brb_phase_e;

typedef struct packed {
	logic trim;
	logic therm;
	logic outLow;
	logic outHigh;
	logic overCur;
} brb_fault_s;

typedef struct packed {
	logic [6:0] setpoint;
	logic stepSize;
	logic forcedMode;
	logic spread;
	logic [1:0] pinRole;
	logic [3:0] rampRate;
} brb_ctrl_s;

typedef struct packed {
	brb_phase_e phase;
	brb_fault_s faultSync1;
	brb_fault_s faultSync2;
	logic pinSync1;
	logic pinSync2;
	logic pinPrev;
	logic [6:0] ceiling;
	logic cfgStep;
	logic cfgForce;
	logic cfgSpread;
	logic [1:0] cfgRole;
	logic [3:0] slew;
	logic [6:0] target;
	logic thermLat;
	logic overCurLat;
	logic ceilViol;
	logic [7:0] rdData;
	logic cycleStart;
	logic syncOut;
	logic syncOe;
	brb_ctrl_s ctrl;
} brb_state_s;

endpackage

// [testbench/brb_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module brb_host_model (
	input wire logic ref_clk,
	output logic regWrStb,
	output logic regRdStb,
	output logic [7:0] regPtr,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData
);
	initial begin
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		regPtr = 8'h00;
		regWrData = 8'h00;
	end
	// Pointer and data byte in one strobe
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(posedge ref_clk);
		regWrStb <= 1'b1;
		regPtr <= p;
		regWrData <= d;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
		regPtr <= ~p;
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		@(posedge ref_clk);
		regRdStb <= 1'b1;
		regPtr <= p;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		regPtr <= ~p;
		@(posedge ref_clk);
		#1 d = regRdData;
	endtask
endmodule // brb_host_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "brb_map.svh"
module tb import brb_pkg::*; ;
	localparam logic [3:0] PART = 4'h6; // Arbitrary part code
	localparam logic [3:0] REV = 4'h9; // Arbitrary revision code
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic syncPinIn = 1'b0;
	logic internalSwClk = 1'b0;
	logic clkEn = 1'b1;
	brb_fault_s faultPins = 5'h00;
	logic [6:0] ceil, tgt;
	logic [7:0] cfg;
	logic [3:0] slew;
	logic [31:0] seed = 32'h00012B2F;
	wire logic regWrStb, regRdStb;
	wire logic [7:0] regPtr, regWrData;
	logic [7:0] regRdData;
	logic syncPinOut, syncPinOe, cycleStart;
	brb_ctrl_s regCtrl;
	int bad_count = 0;
	int check_count = 0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) internalSwClk <= ~internalSwClk;
	brb_host_model host_u (.ref_clk(ref_clk), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regPtr(regPtr), .regWrData(regWrData),
		.regRdData(regRdData));
	brb_regs #(.PART_CODE(PART), .REV_CODE(REV)) dut_u (.ref_clk(ref_clk),
		.rst_n(rst_n), .clkEn(clkEn), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regPtr(regPtr), .regWrData(regWrData),
		.regRdData(regRdData), .otpCeiling(ceil), .otpConfig(cfg),
		.otpSlew(slew), .otpTarget(tgt), .faultPins(faultPins),
		.syncPinIn(syncPinIn), .internalSwClk(internalSwClk),
		.syncPinOut(syncPinOut), .syncPinOe(syncPinOe),
		.cycleStart(cycleStart), .regCtrl(regCtrl));
	//////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function automatic logic [15:0] ctrlExp();
		logic mode;
		logic [6:0] cap;
		mode = (cfg[1:0] != 2'h0) | cfg[3] | syncPinIn;
		cap = (tgt > ceil) ? ceil : tgt;
		return {cap, cfg[7], mode, cfg[2], cfg[1:0], slew};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic readStatus(input logic [7:0] flags);
		logic [7:0] rd;
		host_u.rd(`BRB_OFS_STATUS, rd);
		chk(rd, flags | {6'h00, tgt > ceil, 1'b0});
	endtask
	task automatic putReg(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] rd;
		host_u.wr(p, d);
		if (p == `BRB_OFS_CEIL) ceil = d[6:0];
		if (p == `BRB_OFS_TARGET) tgt = d[6:0];
		if (p == `BRB_OFS_SLEW) slew = d[3:0];
		if (p == `BRB_OFS_CONFIG) cfg = d;
		repeat (4) @(posedge ref_clk);
		#1 chk(regCtrl, ctrlExp());
		chk(syncPinOe, cfg[1:0] != 2'h0);
		chk(syncPinOut, (cfg[1:0] != 2'h0) & ~internalSwClk);
		host_u.rd(p, rd);
		chk(rd, d & ((p == `BRB_OFS_CONFIG) ? 8'h8F : (p == `BRB_OFS_SLEW) ?
			8'h0F : 8'h7F));
		readStatus(8'h00);
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] rd;
		logic [7:0] rsv [3];
		logic [4:0] pins [5];
		logic [7:0] bits [5];
		int n;
		rsv = '{8'h01, 8'h03, 8'h2B};
		pins = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
		bits = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
		rd = rnd();
		ceil = rd[6:0];
		rd = rnd();
		tgt = rd[6:0];
		cfg = rnd() & 8'hF4;
		rd = rnd();
		slew = rd[3:0];
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 chk(regCtrl, ctrlExp());
		readStatus(8'h00);
		host_u.wr(`BRB_OFS_ID, 8'hFF);
		host_u.rd(`BRB_OFS_ID, rd);
		chk(rd, {PART, REV});
		foreach (rsv[i]) begin
			host_u.wr(rsv[i], 8'hFF);
			host_u.rd(rsv[i], rd);
			chk(rd, 8'h00);
		end
		putReg(`BRB_OFS_CEIL, 8'h90);
		putReg(`BRB_OFS_TARGET, 8'h10);
		putReg(`BRB_OFS_TARGET, 8'h11);
		for (int i = 0; i < 24; i++) begin
			rd = rnd();
			@(posedge ref_clk);
			syncPinIn <= rd[5];
			putReg(rd[1] ? `BRB_OFS_CONFIG : rd[0] ? `BRB_OFS_CEIL :
				`BRB_OFS_TARGET, rnd());
			putReg(`BRB_OFS_SLEW, rnd());
		end
		@(posedge ref_clk);
		syncPinIn <= 1'b0;
		putReg(`BRB_OFS_CONFIG, 8'h08);
		putReg(`BRB_OFS_CONFIG, 8'h00);
		n = 0;
		@(posedge ref_clk);
		syncPinIn <= 1'b1;
		repeat (6) begin
			@(posedge ref_clk);
			#1 n += cycleStart;
		end
		chk(n, 1);
		@(posedge ref_clk);
		clkEn <= 1'b0;
		host_u.wr(`BRB_OFS_TARGET, {1'b0, ~tgt});
		@(posedge ref_clk);
		clkEn <= 1'b1;
		host_u.rd(`BRB_OFS_TARGET, rd);
		chk(rd, {1'b0, tgt});
		foreach (pins[i]) begin
			@(posedge ref_clk);
			faultPins <= pins[i];
			repeat (4) @(posedge ref_clk);
			if (bits[i] == 8'h20 || bits[i] == 8'h04) faultPins <= 5'h00;
			repeat (4) @(posedge ref_clk);
			readStatus(bits[i]);
			@(posedge ref_clk);
			faultPins <= 5'h00;
			repeat (4) @(posedge ref_clk);
			readStatus(8'h00);
		end
		results;
	end
	initial begin
		#400000;
		bad_count++;
		results;
	end
endmodule // tb
`default_nettype wire

// [verilog/brb_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "brb_map.svh"

module brb_regs
	import brb_pkg::*;
#(
	parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value
	parameter logic [3:0] REV_CODE = 4'hA // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regPtr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic [6:0] otpCeiling,
	input wire logic [7:0] otpConfig,
	input wire logic [3:0] otpSlew,
	input wire logic [6:0] otpTarget,
	input wire brb_fault_s faultPins,
	input wire logic syncPinIn,
	input wire logic internalSwClk,
	output logic syncPinOut,
	output logic syncPinOe,
	output logic cycleStart,
	output brb_ctrl_s regCtrl
);

brb_state_s st_reg;
brb_state_s st_next;
logic [7:0] statusVal;
logic [7:0] readVal;
logic statusRd;

////////////////////////////////////////////////////////////////////////
// Read view

always_comb begin
	statusVal = `BRB_STATUS_RST;
	statusVal[`BRB_ST_TRIM] = st_reg.faultSync2.trim;
	statusVal[`BRB_ST_THERM] = st_reg.thermLat;
	statusVal[`BRB_ST_LOW] = st_reg.faultSync2.outLow;
	statusVal[`BRB_ST_HIGH] = st_reg.faultSync2.outHigh;
	statusVal[`BRB_ST_OVERCUR] = st_reg.overCurLat;
	statusVal[`BRB_ST_CEIL] = st_reg.ceilViol;
end

always_comb begin
	readVal = 8'h00;
	if (regPtr == `BRB_OFS_ID) begin
		readVal = {PART_CODE, REV_CODE};
	end else if (regPtr == `BRB_OFS_CEIL) begin
		readVal = {1'b0, st_reg.ceiling};
	end else if (regPtr == `BRB_OFS_STATUS) begin
		readVal = statusVal;
	end else if (regPtr == `BRB_OFS_CONFIG) begin
		readVal = {st_reg.cfgStep, 3'h0, st_reg.cfgForce,
			st_reg.cfgSpread, st_reg.cfgRole};
	end else if (regPtr == `BRB_OFS_SLEW) begin
		readVal = {4'h0, st_reg.slew};
	end else if (regPtr == `BRB_OFS_TARGET) begin
		readVal = {1'b0, st_reg.target};
	end
end

assign statusRd = regRdStb && (regPtr == `BRB_OFS_STATUS);

////////////////////////////////////////////////////////////////////////
// Next state

always_comb begin
	st_next = st_reg;
	if (clkEn) begin
		st_next.faultSync1 = faultPins;
		st_next.faultSync2 = st_reg.faultSync1;
		st_next.pinSync1 = syncPinIn;
		st_next.pinSync2 = st_reg.pinSync1;
		st_next.pinPrev = st_reg.pinSync2;
		case (st_reg.phase)
			BRB_LOAD_OTP: begin
				st_next.ceiling = otpCeiling;
				st_next.cfgStep = otpConfig[`BRB_CFG_STEP];
				st_next.cfgForce = otpConfig[`BRB_CFG_FORCE];
				st_next.cfgSpread = otpConfig[`BRB_CFG_SPREAD];
				st_next.cfgRole = otpConfig[`BRB_CFG_ROLE_HI:`BRB_CFG_ROLE_LO];
				st_next.slew = otpSlew;
				st_next.target = otpTarget;
				st_next.phase = BRB_RUN;
			end
			BRB_RUN: begin
				if (regWrStb) begin
					if (regPtr == `BRB_OFS_CEIL) begin
						st_next.ceiling = regWrData[`BRB_CODE_HI:0];
					end else if (regPtr == `BRB_OFS_CONFIG) begin
						st_next.cfgStep = regWrData[`BRB_CFG_STEP];
						st_next.cfgForce = regWrData[`BRB_CFG_FORCE];
						st_next.cfgSpread = regWrData[`BRB_CFG_SPREAD];
						st_next.cfgRole =
							regWrData[`BRB_CFG_ROLE_HI:`BRB_CFG_ROLE_LO];
					end else if (regPtr == `BRB_OFS_SLEW) begin
						st_next.slew = regWrData[`BRB_SLEW_HI:0];
					end else if (regPtr == `BRB_OFS_TARGET) begin
						st_next.target = regWrData[`BRB_CODE_HI:0];
					end
				end
				if (regRdStb) begin
					st_next.rdData = readVal;
				end
			end
			default: begin
				st_next.phase = BRB_LOAD_OTP;
			end
		endcase
		// Clear on status read, a new event wins
		st_next.thermLat = (st_reg.thermLat & ~statusRd)
			| st_reg.faultSync2.therm;
		st_next.overCurLat = (st_reg.overCurLat & ~statusRd)
			| st_reg.faultSync2.overCur;
		st_next.ceilViol = st_next.target > st_next.ceiling;
		st_next.ctrl.setpoint = st_next.ceilViol
			? st_next.ceiling : st_next.target;
		st_next.ctrl.stepSize = st_next.cfgStep;
		st_next.ctrl.spread = st_next.cfgSpread;
		st_next.ctrl.pinRole = st_next.cfgRole;
		st_next.ctrl.rampRate = st_next.slew;
		if (st_next.cfgRole != `BRB_ROLE_INPUT) begin
			st_next.ctrl.forcedMode = 1'b1;
		end else if (st_next.cfgForce) begin
			st_next.ctrl.forcedMode = 1'b1;
		end else begin
			st_next.ctrl.forcedMode = st_reg.pinSync2;
		end
		st_next.syncOe = st_next.cfgRole != `BRB_ROLE_INPUT;
		st_next.syncOut = st_next.syncOe & internalSwClk;
		st_next.cycleStart = (st_reg.cfgRole == `BRB_ROLE_INPUT)
			& st_reg.pinSync2 & ~st_reg.pinPrev;
	end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		st_reg <= '0;
	end else begin
		st_reg <= st_next;
	end
end

assign regRdData = st_reg.rdData;
assign regCtrl = st_reg.ctrl;
assign syncPinOut = st_reg.syncOut;
assign syncPinOe = st_reg.syncOe;
assign cycleStart = st_reg.cycleStart;

////////////////////////////////////////////////////////////////////////
// Checks

chk_setpoint_cap: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	regCtrl.setpoint <= st_reg.ceiling)
	else $error("setpoint above ceiling");

chk_ceil_flag: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	st_reg.phase == BRB_RUN |->
	st_reg.ceilViol == (st_reg.target > st_reg.ceiling))
	else $error("ceiling violation flag wrong");

chk_id_read: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	clkEn && st_reg.phase == BRB_RUN && regRdStb
	&& regPtr == `BRB_OFS_ID |=> regRdData == {PART_CODE, REV_CODE})
	else $error("id readback wrong");

chk_reserved_zero: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	clkEn && st_reg.phase == BRB_RUN && regRdStb
	&& (regPtr == `BRB_OFS_RSVA || regPtr == `BRB_OFS_RSVB
	|| regPtr == `BRB_OFS_SPARE) |=> regRdData == 8'h00)
	else $error("reserved register not zero");

chk_status_bits: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	clkEn && st_reg.phase == BRB_RUN && statusRd
	|=> regRdData[0] == 1'b0 && regRdData[6] == 1'b0
	&& regRdData[`BRB_ST_THERM] == $past(st_reg.thermLat))
	else $error("status readback wrong");

chk_therm_clear: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	clkEn && statusRd && !st_reg.faultSync2.therm |=> !st_reg.thermLat)
	else $error("thermal flag not cleared by read");

chk_latch_hold: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	st_reg.overCurLat && !(clkEn && statusRd) |=> st_reg.overCurLat)
	else $error("overcurrent flag lost without read");

chk_target_write: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	clkEn && st_reg.phase == BRB_RUN && regWrStb
	&& regPtr == `BRB_OFS_TARGET |=> st_reg.target == $past(regWrData[6:0]))
	else $error("target write not loaded");

chk_role_forced: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	st_reg.phase == BRB_RUN && st_reg.cfgRole != `BRB_ROLE_INPUT
	|-> regCtrl.forcedMode && syncPinOe)
	else $error("output pin role without forced mode");

chk_force_bit: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	st_reg.phase == BRB_RUN && st_reg.cfgForce |-> regCtrl.forcedMode)
	else $error("force bit not honoured");

chk_edge_start: assert property (
	@(posedge ref_clk) disable iff (!rst_n)
	cycleStart |-> $past(st_reg.cfgRole) == `BRB_ROLE_INPUT
	&& $past(st_reg.pinSync2) && !$past(st_reg.pinPrev))
	else $error("cycle start without rising edge");

endmodule // brb_regs
`default_nettype wire
